//--- rtl/fbmpc_pkg.sv
package fbmpc_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned RESET_MIN_NS = 100;
   localparam int unsigned RESET_ABORT_MAX_US = 25;
   localparam int unsigned SLEEP_EXIT_US = 75;
   // Least times round up, longest times round down, never below one cycle.
   localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned RESET_ABORT_CYC = RESET_ABORT_MAX_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SLEEP_EXIT_CYC = SLEEP_EXIT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 16;
   localparam logic [15:0] STATUS_READY = 16'h0080;
   localparam int unsigned CFG_SLEEP_POL = 14;
   localparam int unsigned CFG_SLEEP_EN = 15;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   typedef enum logic [2:0]
   {
      FBMPC_ST_RESET,
      FBMPC_ST_STANDBY,
      FBMPC_ST_READ,
      FBMPC_ST_WRITE,
      FBMPC_ST_OUT_DIS,
      FBMPC_ST_SLEEP,
      FBMPC_ST_WAKE
   } fbmpc_state_t;

   // Control pins of the flash bus; all active low except sleep_request, whose polarity is set by the configuration register.
   typedef struct packed
   {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic rst_pin_n;
      logic sleep_request;
   } fbmpc_ctrl_t;

   // Command write strobe handed to the command interpreter.
   typedef struct packed
   {
      logic valid;
      logic [15:0] data;
   } fbmpc_cmd_t;
endpackage

//--- rtl/fbmpc_cnt.sv
`timescale 1ns/1ps
// Load-and-count-down timer shared by reset and wake sequencing.
module fbmpc_cnt #(
   parameter int unsigned W = 16
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] load_value,
   output logic done
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   // Reload wins over counting so a fresh interval always starts full.
   always_comb
   begin
      next_cnt = cnt;
      if (load)
         next_cnt = load_value;
      else if (cnt != '0)
         next_cnt = cnt - W'(1);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign done = (cnt == '0) && !load;
endmodule

//--- rtl/fbmpc_top.sv
`timescale 1ns/1ps
// Bus-operation decode, reset sequencing and deep power-down sequencing.
module fbmpc_top #(
   parameter int unsigned RESET_ABORT_CYC = fbmpc_pkg::RESET_ABORT_CYC,
   parameter int unsigned SLEEP_EXIT_CYC = fbmpc_pkg::SLEEP_EXIT_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire fbmpc_pkg::fbmpc_ctrl_t ctrl,
   input wire logic [15:0] dq_in,
   input wire logic [15:0] array_rdata,
   input wire logic busy,
   input wire logic [15:0] cfg_in,
   input wire logic cfg_load,
   input wire logic [15:0] status_in,
   output logic dq_oe_n,
   output logic [15:0] dq_out,
   output fbmpc_pkg::fbmpc_cmd_t cmd,
   output logic abort,
   output logic [15:0] status,
   output logic [15:0] extended_config_register,
   output logic in_sleep,
   output logic ready,
   output fbmpc_pkg::fbmpc_state_t state
);
   fbmpc_pkg::fbmpc_state_t next_state;
   logic next_dq_oe_n;
   logic [15:0] next_dq_out;
   fbmpc_pkg::fbmpc_cmd_t next_cmd;
   logic next_abort;
   logic [15:0] next_status;
   logic [15:0] next_cfg;
   logic next_ready;
   logic we_d;
   logic tmr_load;
   logic [fbmpc_pkg::CNT_W-1:0] tmr_value;
   logic tmr_done;
   logic sleep_asserted;
   logic sleep_enter;

   // Polarity bit zero means a low pin level requests sleep.
   function automatic logic sleep_level(input logic pin, input logic pol);
      sleep_level = pol ? pin : !pin;
   endfunction

   assign sleep_asserted = sleep_level(ctrl.sleep_request, extended_config_register[fbmpc_pkg::CFG_SLEEP_POL]);
   assign sleep_enter = sleep_asserted && extended_config_register[fbmpc_pkg::CFG_SLEEP_EN];

   fbmpc_cnt #(.W(fbmpc_pkg::CNT_W)) u_tmr (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .load_value(tmr_value),
      .done(tmr_done)
   );

   // Operation decode; reset pin dominates everything, then sleep, then the bus.
   always_comb
   begin
      next_state = state;
      tmr_load = 1'b0;
      tmr_value = '0;
      case (state)
         fbmpc_pkg::FBMPC_ST_RESET:
         begin
            // The timer runs from the assertion edge, so a long pulse never stretches the abort limit.
            if (ctrl.rst_pin_n && tmr_done)
               next_state = fbmpc_pkg::FBMPC_ST_STANDBY;
         end
         fbmpc_pkg::FBMPC_ST_SLEEP:
         begin
            if (!sleep_asserted)
            begin
               tmr_load = 1'b1;
               tmr_value = fbmpc_pkg::CNT_W'(SLEEP_EXIT_CYC);
               next_state = fbmpc_pkg::FBMPC_ST_WAKE;
            end
         end
         fbmpc_pkg::FBMPC_ST_WAKE:
         begin
            if (sleep_enter)
               next_state = fbmpc_pkg::FBMPC_ST_SLEEP;
            else if (tmr_done)
               next_state = fbmpc_pkg::FBMPC_ST_STANDBY;
         end
         fbmpc_pkg::FBMPC_ST_STANDBY, fbmpc_pkg::FBMPC_ST_READ, fbmpc_pkg::FBMPC_ST_WRITE,
         fbmpc_pkg::FBMPC_ST_OUT_DIS:
         begin
            if (sleep_enter)
               next_state = fbmpc_pkg::FBMPC_ST_SLEEP;
            else if (ctrl.ce_n)
               next_state = fbmpc_pkg::FBMPC_ST_STANDBY;
            else if (!ctrl.oe_n && ctrl.we_n)
               next_state = fbmpc_pkg::FBMPC_ST_READ;
            else if (ctrl.oe_n && !ctrl.we_n)
               next_state = fbmpc_pkg::FBMPC_ST_WRITE;
            else
               next_state = fbmpc_pkg::FBMPC_ST_OUT_DIS;
         end
         default:
            next_state = fbmpc_pkg::FBMPC_ST_STANDBY;
      endcase
      // Reset pin overrides every other state; the timer is loaded once, on entry.
      if (!ctrl.rst_pin_n)
      begin
         if (state != fbmpc_pkg::FBMPC_ST_RESET)
         begin
            // A running program or erase needs the long abort; otherwise the short pulse suffices.
            tmr_load = 1'b1;
            if (busy)
               tmr_value = fbmpc_pkg::CNT_W'(RESET_ABORT_CYC);
            else
               tmr_value = fbmpc_pkg::CNT_W'(fbmpc_pkg::RESET_MIN_CYC);
         end
         next_state = fbmpc_pkg::FBMPC_ST_RESET;
      end
   end

   // Data bus, command strobe and status; bus enable, data and ready follow the decoded next state, the command strobe the current state.
   always_comb
   begin
      next_dq_oe_n = 1'b1;
      next_dq_out = dq_out;
      next_cmd = '0;
      next_abort = 1'b0;
      next_status = status_in;
      next_cfg = extended_config_register;
      next_ready = (next_state != fbmpc_pkg::FBMPC_ST_RESET) && (next_state != fbmpc_pkg::FBMPC_ST_SLEEP)
                   && (next_state != fbmpc_pkg::FBMPC_ST_WAKE);
      if (next_state == fbmpc_pkg::FBMPC_ST_READ)
      begin
         next_dq_oe_n = 1'b0;
         next_dq_out = array_rdata;
      end
      // Commands are taken on the rising edge of write enable, never in reset.
      if (state == fbmpc_pkg::FBMPC_ST_WRITE && ctrl.we_n && !we_d && ctrl.rst_pin_n)
      begin
         next_cmd.valid = 1'b1;
         next_cmd.data = dq_in;
      end
      if (cfg_load && state != fbmpc_pkg::FBMPC_ST_RESET && state != fbmpc_pkg::FBMPC_ST_SLEEP)
         next_cfg = cfg_in;
      if (!ctrl.rst_pin_n && state != fbmpc_pkg::FBMPC_ST_RESET && busy)
         next_abort = 1'b1;
      // Configuration survives sleep; status is forced back to ready.
      if (next_state == fbmpc_pkg::FBMPC_ST_SLEEP || state == fbmpc_pkg::FBMPC_ST_SLEEP)
         next_status = fbmpc_pkg::STATUS_READY;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= fbmpc_pkg::FBMPC_ST_RESET;
         dq_oe_n <= 1'b1;
         dq_out <= 16'h0000;
         cmd <= '0;
         abort <= 1'b0;
         status <= fbmpc_pkg::STATUS_READY;
         extended_config_register <= fbmpc_pkg::CFG_RESET;
         in_sleep <= 1'b0;
         ready <= 1'b0;
         we_d <= 1'b1;
      end
      else
      begin
         state <= next_state;
         dq_oe_n <= next_dq_oe_n;
         dq_out <= next_dq_out;
         cmd <= next_cmd;
         abort <= next_abort;
         status <= next_status;
         extended_config_register <= next_cfg;
         in_sleep <= (next_state == fbmpc_pkg::FBMPC_ST_SLEEP);
         ready <= next_ready;
         we_d <= ctrl.we_n;
      end
   end

   property p_float_unless_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (state != fbmpc_pkg::FBMPC_ST_READ) |-> dq_oe_n;
   endproperty
   a_float_unless_read: assert property (p_float_unless_read) else $error("Data bus driven outside read.");

   property p_read_drives;
      @(posedge ref_clk) disable iff (!rst_n)
      (ctrl.rst_pin_n && !ctrl.ce_n && !ctrl.oe_n && ctrl.we_n && !sleep_enter
       && state inside {fbmpc_pkg::FBMPC_ST_STANDBY, fbmpc_pkg::FBMPC_ST_OUT_DIS})
      |=> (!dq_oe_n && dq_out == $past(array_rdata));
   endproperty
   a_read_drives: assert property (p_read_drives) else $error("Read did not drive data.");

   property p_write_state;
      @(posedge ref_clk) disable iff (!rst_n)
      (ctrl.rst_pin_n && !ctrl.ce_n && ctrl.oe_n && !ctrl.we_n && !sleep_enter && ready)
      |=> (state == fbmpc_pkg::FBMPC_ST_WRITE && dq_oe_n);
   endproperty
   a_write_state: assert property (p_write_state) else $error("Write not decoded.");

   property p_reset_ignores;
      @(posedge ref_clk) disable iff (!rst_n)
      !ctrl.rst_pin_n |=> (state == fbmpc_pkg::FBMPC_ST_RESET && !cmd.valid && dq_oe_n);
   endproperty
   a_reset_ignores: assert property (p_reset_ignores) else $error("Bus active during reset.");

   property p_cmd_only_from_write;
      @(posedge ref_clk) disable iff (!rst_n)
      cmd.valid |-> ($past(state, 2) == fbmpc_pkg::FBMPC_ST_WRITE || $past(state) == fbmpc_pkg::FBMPC_ST_WRITE);
   endproperty
   a_cmd_only_from_write: assert property (p_cmd_only_from_write) else $error("Command without write.");

   property p_select_needed;
      @(posedge ref_clk) disable iff (!rst_n)
      (ctrl.ce_n && ready) |=> state inside {fbmpc_pkg::FBMPC_ST_STANDBY, fbmpc_pkg::FBMPC_ST_SLEEP,
                                             fbmpc_pkg::FBMPC_ST_RESET};
   endproperty
   a_select_needed: assert property (p_select_needed) else $error("Cycle without chip select.");

   property p_sleep_entry;
      @(posedge ref_clk) disable iff (!rst_n)
      (sleep_enter && ctrl.rst_pin_n && state != fbmpc_pkg::FBMPC_ST_RESET)
      |=> (in_sleep && status == fbmpc_pkg::STATUS_READY);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep entry wrong.");

   property p_no_sleep_without_enable;
      @(posedge ref_clk) disable iff (!rst_n)
      !extended_config_register[fbmpc_pkg::CFG_SLEEP_EN] && state != fbmpc_pkg::FBMPC_ST_SLEEP |=> !in_sleep;
   endproperty
   a_no_sleep_without_enable: assert property (p_no_sleep_without_enable) else $error("Sleep while disabled.");

   property p_wake_not_early;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == fbmpc_pkg::FBMPC_ST_SLEEP && !sleep_asserted && ctrl.rst_pin_n) |=> !ready [*3];
   endproperty
   a_wake_not_early: assert property (p_wake_not_early) else $error("Wake too early.");

   property p_reset_short;
      @(posedge ref_clk) disable iff (!rst_n)
      ($fell(ctrl.rst_pin_n) && !busy && state != fbmpc_pkg::FBMPC_ST_RESET) ##4 ctrl.rst_pin_n [*2]
      |-> ##[0:1] ready;
   endproperty
   a_reset_short: assert property (p_reset_short) else $error("Short reset overran.");

   property p_abort_pulse;
      @(posedge ref_clk) disable iff (!rst_n)
      ($fell(ctrl.rst_pin_n) && busy && state != fbmpc_pkg::FBMPC_ST_RESET) |=> abort ##1 !abort;
   endproperty
   a_abort_pulse: assert property (p_abort_pulse) else $error("Abort pulse missing.");

   c_read: cover property (@(posedge ref_clk) disable iff (!rst_n) state == fbmpc_pkg::FBMPC_ST_READ);
   c_cmd: cover property (@(posedge ref_clk) disable iff (!rst_n) cmd.valid);
   c_sleep_wake: cover property (@(posedge ref_clk) disable iff (!rst_n)
      state == fbmpc_pkg::FBMPC_ST_WAKE ##1 state == fbmpc_pkg::FBMPC_ST_STANDBY);
   c_abort: cover property (@(posedge ref_clk) disable iff (!rst_n) abort);
endmodule

//--- dv/fbmpc_host.sv
`timescale 1ns/1ps
// Host controller model; pins change only just after a rising edge.
module fbmpc_host (
   input wire logic ref_clk,
   output fbmpc_pkg::fbmpc_ctrl_t ctrl,
   output logic [15:0] dq_in
);
   // Idle: deselected, reset off, sleep request high.
   initial
   begin
      ctrl = 5'b11111;
      dq_in = 16'h0000;
   end

   // Order is select, output enable, write enable, reset, sleep request.
   task automatic pins(input logic [4:0] v);
      @(posedge ref_clk);
      ctrl <= v;
      #1;
   endtask

   // Output enable stays high for the whole write, so both enables are never low at once.
   task automatic write_word(input logic [15:0] d, input logic rp);
      pins({3'b010, rp, ctrl.sleep_request});
      repeat (2) @(posedge ref_clk);
      ctrl.we_n <= 1'b1;
      dq_in <= d;
      repeat (2) @(posedge ref_clk);
      ctrl.ce_n <= 1'b1;
      dq_in <= ~d; // A released bus must not keep showing the old word.
      #1;
   endtask

   // Select is already high when the request arrives.
   task automatic sleep_enter(input logic lvl);
      pins({4'b1111, lvl});
   endtask

   // Releasing the request ends sleep; the caller then waits out the exit time.
   task automatic sleep_exit(input logic lvl, input int wake);
      @(posedge ref_clk);
      ctrl.sleep_request <= ~lvl;
      repeat (wake) @(posedge ref_clk);
      #1;
   endtask
endmodule

//--- dv/fbmpc_top_tb.sv
`timescale 1ns/1ps
module fbmpc_top_tb;
   localparam int RA = 8;
   localparam int SX = 10;
   logic ref_clk, rst_n, busy, cfg_load, dq_oe_n, abort, in_sleep, ready;
   logic [15:0] dq_in, array_rdata, cfg_in, status_in, dq_out, status, ext_cfg, last_cmd;
   fbmpc_pkg::fbmpc_ctrl_t ctrl;
   fbmpc_pkg::fbmpc_cmd_t cmd;
   fbmpc_pkg::fbmpc_state_t state;
   int fails = 0;
   int cmp_count = 0;
   int n_cmd = 0;
   int n_abort = 0;
   int n0;

   fbmpc_host host_u (.ref_clk(ref_clk), .ctrl(ctrl), .dq_in(dq_in));

   fbmpc_top #(.RESET_ABORT_CYC(RA), .SLEEP_EXIT_CYC(SX)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .ctrl(ctrl), .dq_in(dq_in), .array_rdata(array_rdata),
      .busy(busy), .cfg_in(cfg_in), .cfg_load(cfg_load), .status_in(status_in), .dq_oe_n(dq_oe_n),
      .dq_out(dq_out), .cmd(cmd), .abort(abort), .status(status), .extended_config_register(ext_cfg),
      .in_sleep(in_sleep), .ready(ready), .state(state));

   // Free-running 40 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Pulses are counted, so a stretched or lost pulse shows in the totals.
   always @(posedge ref_clk)
   begin
      if (cmd.valid === 1'b1)
      begin
         n_cmd++;
         last_cmd <= cmd.data;
      end
      if (abort === 1'b1)
         n_abort++;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wait_ready(input int lim);
      for (int i = 0; i < lim && ready !== 1'b1; i++)
         cyc(1);
      check("ready", 16'(ready), 16'h0001);
   endtask

   task automatic load_cfg(input logic [15:0] v);
      @(posedge ref_clk);
      cfg_in <= v;
      cfg_load <= 1'b1;
      @(posedge ref_clk);
      cfg_load <= 1'b0;
      #1;
   endtask

   task automatic t_read();
      @(posedge ref_clk);
      array_rdata <= 16'h5a3c;
      host_u.pins(5'b00111);
      cyc(3);
      check("dq_oe_n", 16'(dq_oe_n), 16'h0000);
      check("dq_out", dq_out, 16'h5a3c);
      check("state", 16'(state), 16'(fbmpc_pkg::FBMPC_ST_READ));
      // A new word at the same read must reach the bus while output enable stays low.
      @(posedge ref_clk);
      array_rdata <= 16'hc3a5;
      cyc(2);
      check("dq_out", dq_out, 16'hc3a5);
      host_u.pins(5'b01111);
      cyc(3);
      check("dq_oe_n", 16'(dq_oe_n), 16'h0001);
      host_u.pins(5'b10111);
      cyc(3);
      check("dq_oe_n", 16'(dq_oe_n), 16'h0001);
   endtask

   // Three writes back to back must give exactly three one-cycle pulses.
   task automatic t_write();
      n0 = n_cmd;
      host_u.write_word(16'h00ff, 1'b1);
      host_u.write_word(16'h0060, 1'b1);
      host_u.write_word(16'h00d0, 1'b1);
      cyc(2);
      check("cmd_count", 16'(n_cmd - n0), 16'h0003);
      check("cmd_data", last_cmd, 16'h00d0);
      check("state", 16'(state), 16'(fbmpc_pkg::FBMPC_ST_STANDBY));
   endtask

   task automatic t_reset_idle();
      n0 = n_cmd;
      host_u.pins(5'b00101);
      cyc(3);
      check("dq_oe_n", 16'(dq_oe_n), 16'h0001);
      load_cfg(16'h8000);
      check("cfg", ext_cfg, 16'h0000);
      host_u.write_word(16'h0070, 1'b0);
      host_u.pins(5'b11111);
      wait_ready(fbmpc_pkg::RESET_MIN_CYC + 3);
      check("cmd_count", 16'(n_cmd - n0), 16'h0000);
      // A pulse of exactly the minimum width with nothing running must keep ready low one cycle after it ends and raise it the next.
      host_u.pins(5'b11101);
      cyc(fbmpc_pkg::RESET_MIN_CYC - 1);
      host_u.pins(5'b11111);
      cyc(1);
      check("ready", 16'(ready), 16'h0000);
      cyc(1);
      check("ready", 16'(ready), 16'h0001);
   endtask

   task automatic t_reset_busy();
      n0 = n_abort;
      @(posedge ref_clk);
      busy <= 1'b1;
      host_u.pins(5'b11101);
      cyc(4);
      @(posedge ref_clk);
      busy <= 1'b0;
      host_u.pins(5'b11111);
      cyc(3);
      check("ready", 16'(ready), 16'h0000);
      wait_ready(RA + 3);
      check("abort_count", 16'(n_abort - n0), 16'h0001);
   endtask

   // Request first, enable second; the status must be cleared to ready while asleep.
   task automatic t_sleep();
      @(posedge ref_clk);
      status_in <= 16'h00b0;
      host_u.sleep_enter(1'b0);
      cyc(3);
      check("in_sleep", 16'(in_sleep), 16'h0000);
      load_cfg(16'h8000);
      cyc(4);
      check("in_sleep", 16'(in_sleep), 16'h0001);
      check("status", status, 16'h0080);
      check("cfg", ext_cfg, 16'h8000);
      check("state", 16'(state), 16'(fbmpc_pkg::FBMPC_ST_SLEEP));
      // A load while asleep is dropped; had it landed, the new polarity would wake the device.
      load_cfg(16'hc000);
      check("cfg", ext_cfg, 16'h8000);
      check("in_sleep", 16'(in_sleep), 16'h0001);
      check("dq_oe_n", 16'(dq_oe_n), 16'h0001);
      host_u.sleep_exit(1'b0, 3);
      check("in_sleep", 16'(in_sleep), 16'h0000);
      check("ready", 16'(ready), 16'h0000);
      wait_ready(SX + 4);
      check("status", status, 16'h00b0);
   endtask

   // Polarity first, then enable, then a high level as the asserted request.
   task automatic t_polarity();
      load_cfg(16'h4000);
      host_u.pins(5'b11110);
      load_cfg(16'hc000);
      cyc(3);
      check("in_sleep", 16'(in_sleep), 16'h0000);
      host_u.sleep_enter(1'b1);
      cyc(4);
      check("in_sleep", 16'(in_sleep), 16'h0001);
      // Reset in sleep with the request still held: the device falls back asleep.
      host_u.pins(5'b11101);
      cyc(fbmpc_pkg::RESET_MIN_CYC - 1);
      host_u.pins(5'b11111);
      cyc(4);
      check("in_sleep", 16'(in_sleep), 16'h0001);
      host_u.sleep_exit(1'b1, 3);
      wait_ready(SX + 4);
      load_cfg(16'h4000);
      host_u.pins(5'b11111);
      load_cfg(16'h0000);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // The run needs well under a thousand cycles; this cuts a hang short.
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end

   initial
   begin
      rst_n = 1'b0;
      busy = 1'b0;
      cfg_load = 1'b0;
      cfg_in = 16'h0000;
      array_rdata = 16'h0000;
      status_in = 16'h0080;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_ready(8);
      t_read();
      t_write();
      t_reset_idle();
      t_reset_busy();
      t_sleep();
      t_polarity();
      tally_and_finish();
   end
endmodule
